// ===== hdl/mps_pkg.sv
// Package of constants, types and register map for the motion position and status unit.
package mps_pkg;

    // ****************
    // Register map (byte addresses, one aligned word each).
    // ****************
    localparam logic [7:0] ADDR_COMMAND = 8'h00;
    localparam logic [7:0] ADDR_PRESET_STEP = 8'h04;
    localparam logic [7:0] ADDR_PRESET_MICRO = 8'h08;
    localparam logic [7:0] ADDR_PRESET_ENC = 8'h0C;
    localparam logic [7:0] ADDR_CONFIG = 8'h10;
    localparam logic [7:0] ADDR_STEP = 8'h14;
    localparam logic [7:0] ADDR_MICRO = 8'h18;
    localparam logic [7:0] ADDR_ENC = 8'h1C;
    localparam logic [7:0] ADDR_TARGET = 8'h20;
    localparam logic [7:0] ADDR_PRIMARY = 8'h24;
    localparam logic [7:0] ADDR_PRIMARY_MICRO = 8'h28;
    localparam logic [7:0] ADDR_SECONDARY = 8'h2C;
    localparam logic [7:0] ADDR_SPEED = 8'h30;
    localparam logic [7:0] ADDR_MOTION = 8'h34;
    localparam logic [7:0] ADDR_FLAGS = 8'h38;
    localparam logic [7:0] ADDR_SIGNALS = 8'h3C;
    localparam logic [7:0] ADDR_SUPPLY = 8'h40;
    localparam logic [7:0] ADDR_TEMP = 8'h44;
    localparam logic [7:0] ADDR_SNAPSHOT = 8'h48;

    // ****************
    // Command codes written to the command register.
    // ****************
    localparam logic [7:0] CMD_ZERO = 8'h01;
    localparam logic [7:0] CMD_PRESET = 8'h02;
    localparam logic [7:0] CMD_STATUS = 8'h03;
    localparam logic [7:0] CMD_FAST_STOP = 8'h04;
    localparam logic [7:0] CMD_MICROSTEP = 8'h05;
    localparam logic [7:0] CMD_STEPS_REV = 8'h06;
    localparam logic [7:0] MOVE_UNKNOWN = 8'h00;

    // Command word fields.
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_CRC_BAD_BIT = 8;
    localparam int CMD_IGN_POS_BIT = 9;
    localparam int CMD_IGN_ENC_BIT = 10;
    localparam int CMD_ARG_LSB = 16;
    localparam logic [7:0] MICROSTEP_MAX = 8'h09;

    // Configuration word fields.
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_CORR_BIT = 2;

    // ****************
    // Enumerations of modes and states.
    // ****************
    typedef enum logic [1:0] {
        MODE_OPEN_LOOP = 2'h0,
        MODE_LEAD_ENC = 2'h1,
        MODE_ENC_FEEDBACK = 2'h2,
        MODE_DC = 2'h3
    } mps_mode_t;

    typedef enum logic [1:0] {
        PWR_OFF = 2'h0,
        PWR_REDUCED = 2'h1,
        PWR_NOMINAL = 2'h2,
        PWR_LOW_SUPPLY = 2'h3
    } mps_pwr_t;

    typedef enum logic [2:0] {
        ENC_ABSENT = 3'h0,
        ENC_UNKNOWN = 3'h1,
        ENC_WORKING = 3'h2,
        ENC_REVERSED = 3'h3,
        ENC_DEFECTIVE = 3'h4
    } mps_enc_t;

    typedef enum logic [1:0] {
        COIL_OPEN = 2'h0,
        COIL_OK = 2'h1,
        COIL_SHORT = 2'h2,
        COIL_UNKNOWN = 2'h3
    } mps_coil_t;

    // States of the bus slave.
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DATA = 2'b10
    } mps_bus_t;

    // ****************
    // Carriers for groups of signals.
    // ****************
    typedef struct packed {
        logic moving;
        logic speed_reached;
        logic backlash;
        logic [7:0] code;
        logic running;
        logic failed;
    } mps_motion_t;

    typedef struct packed {
        logic drv_overheat;
        logic cpu_temp;
        logic over_volt;
        logic under_volt;
        logic over_curr;
        logic alarm;
        logic limits_swapped;
        logic desync;
    } mps_crit_t;

    typedef struct packed {
        logic [1:0] limit;
        logic [1:0] button;
        logic io_dir_out;
        logic io_active;
        logic [2:0] hall;
        logic brake;
        logic rev_sensor;
        logic sync_in;
        logic sync_out;
        logic [1:0] enc_ch;
    } mps_sig_t;

    localparam int SIG_W = $bits(mps_sig_t);

endpackage : mps_pkg

// ===== hdl/mps_unit.sv
// Position counter adjustment and status reporting unit with an AHB-Lite register slave.
// How it works
// R1: Zero command clears step, microstep and encoder counts in one cycle.
// R2: Zeroing shifts the target by the same amount; motion is not disturbed.
// R3: Preset loads host values; ignore flags select which counters are written.
// R4: Preset leaves the stored move target unchanged.
// R5: Status command snapshots command field, sticky flags and the low 16 bits of the step count for the host.
// R6: Motion flags: moving, speed reached, backlash compensation.
// R7: Command field: current code, running bit, failure bit once done.
// R8: Completion is failed when target or backlash was not achieved.
// R9: After reset the command field reads unknown code and success.
// R10: Winding power state reports four encodings.
// R11: Encoder state reports five encodings, resolved by the motion engine.
// R12: Each of two windings reported separately in four states.
// R13: Leading encoder mode puts encoder in primary field, microstep zero.
// R14: Secondary field: encoder, steps or zero by mode; speed primary units.
// R15: Supply current mA, voltage 10 mV units, temperature 0.1 degree.
// R16: Sticky error flags clear only on the fast stop command.
// R17: Sticky flags for unknown command, bad check code, rejected value.
// R18: Bad microstep mode or zero steps per revolution raise rejection.
// R19: Critical flags follow their sources; alarm and swapped limits stick.
// R20: Desync flag is sticky unless position correction is enabled.
// R21: Switch, button, io and sync flags report the active state.
// R22: Hall and encoder channel flags read 1 on a logic high input.
//
// Our own choices: the address map and the AHB-Lite slave port.
module mps_unit import mps_pkg::*; (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Motion engine, same clock.
    input wire logic step_inc,
    input wire logic step_dec,
    input wire logic enc_inc,
    input wire logic enc_dec,
    input wire logic [31:0] speed_in,
    input wire logic [7:0] microspeed_in,
    input wire mps_motion_t motion_in,
    input wire logic move_done,
    input wire logic move_ok,
    input wire logic [31:0] move_target_in,
    input wire logic move_target_load,
    input wire mps_pwr_t pwr_in,
    input wire mps_enc_t enc_state_in,
    input wire mps_coil_t coil_a_in,
    input wire mps_coil_t coil_b_in,
    input wire logic [15:0] supply_ma,
    input wire logic [15:0] supply_10mv,
    input wire logic [15:0] temp_dc,
    input wire mps_crit_t crit_in,
    input wire logic [7:0] microstep_in,
    // Digital signals from pins, asynchronous.
    input wire mps_sig_t pin_raw,
    input wire mps_sig_t pin_invert,
    // Counters toward the motion engine.
    output logic [31:0] step_count,
    output logic [7:0] micro_count,
    output logic [31:0] enc_count,
    output logic [31:0] target_pos
);

    // ****************
    // Pin synchronisers.
    // ****************
    mps_sig_t sync1_q, sync2_q;

    // Two flip-flops before any logic sees the pins.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    // ****************
    // Bus slave.
    // ****************
    mps_bus_t bus_q, bus_d;
    logic wr_q, wr_d;
    logic [7:0] addr_q, addr_d;
    logic [31:0] rdata_d;
    logic wr_now;

    // Address phase is taken when selected, active and the bus is ready.
    always_comb begin
        bus_d = BUS_IDLE;
        wr_d = 1'b0;
        addr_d = addr_q;
        if (hsel && hready && htrans[1]) begin
            bus_d = BUS_DATA;
            wr_d = hwrite;
            addr_d = haddr[7:0];
        end
    end

    assign wr_now = (bus_q == BUS_DATA) && wr_q;

    // ****************
    // Counters, target, command and flags.
    // ****************
    logic [31:0] step_q, step_d, enc_q, enc_d, tgt_q, tgt_d;
    logic [7:0] micro_q, micro_d;
    logic [31:0] pstep_q, pstep_d, penc_q, penc_d, cfg_q, cfg_d;
    logic [7:0] pmicro_q, pmicro_d;
    logic [7:0] code_q, code_d;
    logic run_q, run_d, fail_q, fail_d;
    logic errc_q, errc_d, errd_q, errd_d, errv_q, errv_d;
    logic alarm_q, alarm_d, swap_q, swap_d, desync_q, desync_d;
    logic [31:0] snap_q, snap_d;
    mps_mode_t mode;
    logic [7:0] cmd;
    logic [15:0] arg;

    // Signed one-step adjustment from increment and decrement strobes.
    function automatic logic [31:0] step_adj(input logic up, input logic dn);
        step_adj = (up && !dn) ? 32'h0000_0001 : ((dn && !up) ? 32'hFFFF_FFFF : 32'h0);
    endfunction : step_adj

    assign mode = mps_mode_t'(cfg_q[CFG_MODE_LSB +: 2]);
    assign cmd = hwdata[CMD_CODE_LSB +: 8];
    assign arg = hwdata[CMD_ARG_LSB +: 16];

    // Next state of counters and flags for counting and host writes.
    always_comb begin
        step_d = step_q + step_adj(step_inc, step_dec);
        enc_d = enc_q + step_adj(enc_inc, enc_dec);
        micro_d = microstep_in;
        tgt_d = move_target_load ? move_target_in : tgt_q;
        pstep_d = pstep_q;
        pmicro_d = pmicro_q;
        penc_d = penc_q;
        cfg_d = cfg_q;
        code_d = code_q;
        run_d = run_q;
        fail_d = fail_q;
        errc_d = errc_q;
        errd_d = errd_q;
        errv_d = errv_q;
        alarm_d = alarm_q | crit_in.alarm;
        swap_d = swap_q | crit_in.limits_swapped;
        snap_d = snap_q;
        // R20: desync sticky
        desync_d = cfg_q[CFG_CORR_BIT] ? crit_in.desync : (desync_q | crit_in.desync);
        // R7: command progress
        if (move_target_load) begin
            code_d = motion_in.code;
            run_d = 1'b1;
            fail_d = 1'b0;
        end
        // R8: failed completion
        if (move_done) begin
            run_d = 1'b0;
            fail_d = !move_ok;
        end
        if (wr_now) begin
            unique case (addr_q)
                ADDR_PRESET_STEP: pstep_d = hwdata;
                ADDR_PRESET_MICRO: pmicro_d = hwdata[7:0];
                ADDR_PRESET_ENC: penc_d = hwdata;
                ADDR_CONFIG: cfg_d = hwdata;
                ADDR_COMMAND: begin
                    if (hwdata[CMD_CRC_BAD_BIT]) begin
                        // R17: bad check code
                        errd_d = 1'b1;
                    end else begin
                        unique case (cmd)
                            CMD_ZERO: begin
                                // R1: zero all counters
                                step_d = 32'h0;
                                micro_d = 8'h0;
                                enc_d = 32'h0;
                                // R2: shift target
                                tgt_d = tgt_q - step_q;
                            end
                            CMD_PRESET: begin
                                // R3: preset with ignore flags
                                if (!hwdata[CMD_IGN_POS_BIT]) begin
                                    step_d = pstep_q;
                                    micro_d = pmicro_q;
                                end
                                if (!hwdata[CMD_IGN_ENC_BIT]) begin
                                    enc_d = penc_q;
                                end
                                // R4: target unchanged
                                tgt_d = tgt_q;
                            end
                            CMD_STATUS: begin
                                // R5: status snapshot
                                snap_d = {code_q, run_q, fail_q, errc_q, errd_q, errv_q,
                                    alarm_q, swap_q, desync_q, step_q[15:0]};
                            end
                            CMD_FAST_STOP: begin
                                // R16: fast stop clears
                                errc_d = 1'b0;
                                errd_d = 1'b0;
                                errv_d = 1'b0;
                                alarm_d = crit_in.alarm;
                                swap_d = crit_in.limits_swapped;
                                desync_d = crit_in.desync;
                            end
                            CMD_MICROSTEP: begin
                                // R18: unsupported microstep
                                if (arg[7:0] > MICROSTEP_MAX) begin
                                    errv_d = 1'b1;
                                end
                            end
                            CMD_STEPS_REV: begin
                                // R18: zero steps per revolution
                                if (arg == 16'h0) begin
                                    errv_d = 1'b1;
                                end
                            end
                            default: begin
                                // R17: unknown command
                                errc_d = 1'b1;
                            end
                        endcase
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Register counters, bus state and flags.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bus_q <= BUS_IDLE;
            wr_q <= 1'b0;
            addr_q <= 8'h0;
            step_q <= 32'h0;
            micro_q <= 8'h0;
            enc_q <= 32'h0;
            tgt_q <= 32'h0;
            pstep_q <= 32'h0;
            pmicro_q <= 8'h0;
            penc_q <= 32'h0;
            cfg_q <= 32'h0;
            // R9: unknown code, success
            code_q <= MOVE_UNKNOWN;
            run_q <= 1'b0;
            fail_q <= 1'b0;
            errc_q <= 1'b0;
            errd_q <= 1'b0;
            errv_q <= 1'b0;
            alarm_q <= 1'b0;
            swap_q <= 1'b0;
            desync_q <= 1'b0;
            snap_q <= 32'h0;
        end else begin
            bus_q <= bus_d;
            wr_q <= wr_d;
            addr_q <= addr_d;
            step_q <= step_d;
            micro_q <= micro_d;
            enc_q <= enc_d;
            tgt_q <= tgt_d;
            pstep_q <= pstep_d;
            pmicro_q <= pmicro_d;
            penc_q <= penc_d;
            cfg_q <= cfg_d;
            code_q <= code_d;
            run_q <= run_d;
            fail_q <= fail_d;
            errc_q <= errc_d;
            errd_q <= errd_d;
            errv_q <= errv_d;
            alarm_q <= alarm_d;
            swap_q <= swap_d;
            desync_q <= desync_d;
            snap_q <= snap_d;
        end
    end

    // ****************
    // Status views and read mux.
    // ****************
    logic [31:0] prim, sec;
    logic [7:0] prim_micro;
    mps_sig_t sig;
    logic [31:0] rdata_q;

    // R13: primary field by mode
    always_comb begin
        prim = (mode == MODE_LEAD_ENC) ? enc_q : step_q;
        prim_micro = (mode == MODE_LEAD_ENC) ? 8'h0 : micro_q;
    end

    // R14: secondary field by mode
    always_comb begin
        unique case (mode)
            MODE_OPEN_LOOP: sec = enc_q;
            MODE_ENC_FEEDBACK: sec = step_q;
            MODE_LEAD_ENC: sec = step_q;
            MODE_DC: sec = 32'h0;
        endcase
    end

    // R21: active state via inversion
    // R22: hall and encoder raw levels
    always_comb begin
        sig = sync2_q ^ pin_invert;
        sig.hall = sync2_q.hall;
        sig.enc_ch = sync2_q.enc_ch;
    end

    // Read data for the address of the current address phase, registered for the data phase.
    always_comb begin
        rdata_d = 32'h0;
        if (bus_d == BUS_DATA && !wr_d) begin
            unique case (addr_d)
                ADDR_PRESET_STEP: rdata_d = pstep_q;
                ADDR_PRESET_MICRO: rdata_d = {24'h0, pmicro_q};
                ADDR_PRESET_ENC: rdata_d = penc_q;
                ADDR_CONFIG: rdata_d = cfg_q;
                ADDR_STEP: rdata_d = step_q;
                ADDR_MICRO: rdata_d = {24'h0, micro_q};
                ADDR_ENC: rdata_d = enc_q;
                ADDR_TARGET: rdata_d = tgt_q;
                ADDR_PRIMARY: rdata_d = prim;
                ADDR_PRIMARY_MICRO: rdata_d = {24'h0, prim_micro};
                ADDR_SECONDARY: rdata_d = sec;
                // R14: speed in primary units
                ADDR_SPEED: rdata_d = speed_in;
                // R6: motion flags
                // R10: power state
                // R11: encoder state
                // R12: two windings
                ADDR_MOTION: rdata_d = {10'h0, coil_b_in, coil_a_in, enc_state_in, pwr_in,
                    motion_in.moving, motion_in.speed_reached, motion_in.backlash,
                    code_q, run_q, fail_q};
                // R19: critical flags
                ADDR_FLAGS: rdata_d = {21'h0, errc_q, errd_q, errv_q, crit_in.drv_overheat,
                    crit_in.cpu_temp, crit_in.over_volt, crit_in.under_volt,
                    crit_in.over_curr, alarm_q, swap_q, desync_q};
                ADDR_SIGNALS: rdata_d = {{(32 - SIG_W){1'b0}}, sig};
                // R15: current and voltage units
                ADDR_SUPPLY: rdata_d = {supply_10mv, supply_ma};
                ADDR_TEMP: rdata_d = {microspeed_in, 8'h0, temp_dc};
                ADDR_SNAPSHOT: rdata_d = snap_q;
                default: rdata_d = 32'h0;
            endcase
        end
    end

    // Registered read data, zero-wait-state slave.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ****************
    // Outputs.
    // ****************
    logic ready_q, resp_q;

    // Ready is held high and the response is OKAY; the slave never inserts wait states.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ready_q <= 1'b1;
            resp_q <= 1'b0;
        end else begin
            ready_q <= 1'b1;
            resp_q <= 1'b0;
        end
    end

    assign hrdata = rdata_q;
    assign hreadyout = ready_q;
    assign hresp = resp_q;
    assign step_count = step_q;
    assign micro_count = micro_q;
    assign enc_count = enc_q;
    assign target_pos = tgt_q;

endmodule : mps_unit

// ===== testbench/mps_host.sv
// Bus master model of the host that reaches the unit over AHB-Lite.
module mps_host (
    // Clock.
    input wire logic clock,
    // Master outputs.
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    // Slave answer.
    input wire logic [31:0] hrdata,
    input wire logic hready
);
    timeunit 1ns;
    timeprecision 1ps;
    // The bus is idle from time zero.
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // Waits for hready at a rising edge and takes the read data standing there.
    task automatic wait_ready(output logic [31:0] rd);
        @(posedge clock);
        while (hready !== 1'b1) begin
            @(posedge clock);
        end
        rd = hrdata;
    endtask : wait_ready
    // One single word transfer: address phase, then data phase.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready(rd);
        hsel <= 1'b0;
        htrans <= 2'h0;
        // A read leaves write data toggling so stale data never looks valid.
        hwdata <= w ? wd : ~hwdata;
        wait_ready(rd);
    endtask : xfer
endmodule : mps_host

// ===== testbench/mps_unit_sva.sv
// Checker of bus answers and counter updates of the position and status unit.
module mps_unit_sva import mps_pkg::*; (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Bus.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Counters and strobes.
    input wire logic step_inc,
    input wire logic step_dec,
    input wire logic [31:0] move_target_in,
    input wire logic move_target_load,
    input wire logic [31:0] step_count,
    input wire logic [31:0] enc_count,
    input wire logic [31:0] target_pos
);
    logic wr_d, wr_q, rd_d, rd_q, cmd_w, zero_w, pre_w;
    logic [7:0] a_d, a_q;
    // Next values of the captured address phase.
    always_comb begin
        wr_d = hsel && hready && htrans[1] && hwrite;
        rd_d = hsel && hready && htrans[1] && !hwrite;
        a_d = haddr[7:0];
    end
    // Register of the captured address phase.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            a_q <= 8'h00;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            a_q <= a_d;
        end
    end
    // Data phase of a command write with a good check code.
    assign cmd_w = wr_q && (a_q == ADDR_COMMAND) && !hwdata[CMD_CRC_BAD_BIT];
    assign zero_w = cmd_w && (hwdata[7:0] == CMD_ZERO);
    assign pre_w = cmd_w && (hwdata[7:0] == CMD_PRESET);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    AST_READY: assert property (hreadyout && !hresp) else $error("bus answer not ready");
    AST_RD_IDLE: assert property (!rd_q |-> hrdata == 32'h0) else $error("read data outside phase");
    AST_ZERO: assert property (zero_w |=> step_count == 32'h0 && enc_count == 32'h0)
        else $error("zero left a counter");
    AST_ZERO_TGT: assert property (zero_w
        |=> target_pos == $past(target_pos) - $past(step_count)) else $error("target not shifted");
    AST_PRE_TGT: assert property (pre_w |=> $stable(target_pos))
        else $error("preset moved target");
    AST_PRE_IGN: assert property (pre_w && hwdata[CMD_IGN_ENC_BIT] |=> $stable(enc_count))
        else $error("ignored encoder written");
    AST_LOAD: assert property (move_target_load && !cmd_w
        |=> target_pos == $past(move_target_in)) else $error("target not loaded");
    AST_STEP: assert property (step_inc && !step_dec && !cmd_w
        |=> step_count == $past(step_count) + 32'h1) else $error("step not counted");
endmodule : mps_unit_sva
bind mps_unit mps_unit_sva u_sva (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .step_inc, .step_dec, .move_target_in,
    .move_target_load, .step_count, .enc_count, .target_pos);

// ===== testbench/mps_unit_tb.sv
// Self-checking testbench of the position and status unit.
module mps_unit_tb;
    import mps_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, rst = 1'b1, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, step_count, enc_count, target_pos, move_target_in = 32'h0;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] micro_count, microspeed_in = 8'h5A;
    logic [15:0] temp_dc = 16'h01C2;
    logic step_inc = 0, step_dec = 0, enc_inc = 0, enc_dec = 0, move_done = 0, move_ok = 0;
    logic move_target_load = 0;
    mps_motion_t motion_in = '0;
    mps_crit_t crit_in = '0;
    mps_pwr_t pwr_in = PWR_LOW_SUPPLY;
    mps_enc_t enc_state_in = ENC_DEFECTIVE;
    mps_coil_t coil_a_in = COIL_SHORT, coil_b_in = COIL_UNKNOWN;
    mps_sig_t pin_raw = 15'h2A5C, pin_invert = 15'h1F0F, sig_e;
    logic [31:0] sec_e [4] = '{32'd50, 32'd100, 32'd100, 32'd0};
    int fails = 0, n_tests = 0;
    always #4 clock = ~clock;
    mps_host host (.clock, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hrdata,
        .hready(hreadyout));
    mps_unit dut (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .step_inc, .step_dec, .enc_inc,
        .enc_dec, .speed_in(32'h0000_1234), .microspeed_in, .motion_in, .move_done, .move_ok,
        .move_target_in, .move_target_load, .pwr_in, .enc_state_in, .coil_a_in, .coil_b_in,
        .supply_ma(16'h0123), .supply_10mv(16'h04B0), .temp_dc, .crit_in,
        .microstep_in(8'h07), .pin_raw, .pin_invert, .step_count, .micro_count, .enc_count,
        .target_pos);
    // Compares a seen value with the expected one.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Register write and checked register read.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        host.xfer(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        host.xfer(1'b0, a, 32'h0, r);
        check(r, e);
    endtask : rd
    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    // Watchdog against a hung handshake.
    initial begin
        #100000;
        fails++;
        summarize();
    end
    // Main sequence.
    initial begin
        sig_e = pin_raw ^ pin_invert;
        sig_e.hall = pin_raw.hall;
        sig_e.enc_ch = pin_raw.enc_ch;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        wr(ADDR_COMMAND, 32'h3);
        rd(ADDR_SNAPSHOT, 32'h0);
        rd(ADDR_SUPPLY, 32'h04B0_0123);
        rd(ADDR_SPEED, 32'h0000_1234);
        rd(ADDR_SIGNALS, {17'h0, sig_e});
        rd(8'hFC, 32'h0);
        move_target_in <= 32'd1000;
        move_target_load <= 1'b1;
        motion_in <= 13'h14A8;
        @(posedge clock);
        move_target_load <= 1'b0;
        step_inc <= 1'b1;
        enc_inc <= 1'b1;
        repeat (3) @(posedge clock);
        enc_inc <= 1'b0;
        repeat (2) @(posedge clock);
        step_inc <= 1'b0;
        @(posedge clock);
        rd(ADDR_STEP, 32'd5);
        wr(ADDR_COMMAND, 32'h1);
        @(posedge clock);
        check({24'h0, micro_count}, 32'h0);
        rd(ADDR_ENC, 32'd0);
        rd(ADDR_TARGET, 32'd995);
        wr(ADDR_COMMAND, 32'h3);
        rd(ADDR_SNAPSHOT, 32'h2A80_0000);
        move_done <= 1'b1;
        @(posedge clock);
        move_done <= 1'b0;
        wr(ADDR_COMMAND, 32'h3);
        rd(ADDR_SNAPSHOT, 32'h2A40_0000);
        rd(ADDR_MOTION, 32'h003A_74A9);
        rd(ADDR_TEMP, 32'h5A00_01C2);
        wr(ADDR_PRESET_STEP, 32'd100);
        wr(ADDR_PRESET_ENC, 32'd50);
        wr(ADDR_COMMAND, 32'h0000_0402);
        rd(ADDR_STEP, 32'd100);
        rd(ADDR_ENC, 32'd0);
        rd(ADDR_TARGET, 32'd995);
        wr(ADDR_COMMAND, 32'h0000_0202);
        rd(ADDR_ENC, 32'd50);
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_CONFIG, 32'(m));
            rd(ADDR_SECONDARY, sec_e[m]);
            if (m < 2) rd(ADDR_PRIMARY, (m == 1) ? 32'd50 : 32'd100);
            if (m < 2) rd(ADDR_PRIMARY_MICRO, (m == 1) ? 32'd0 : 32'd7);
        end
        wr(ADDR_CONFIG, 32'h0);
        crit_in <= 8'h85;
        repeat (3) @(posedge clock);
        crit_in <= 8'h00;
        repeat (3) @(posedge clock);
        wr(ADDR_COMMAND, 32'h7F);
        wr(ADDR_COMMAND, 32'h0000_0103);
        wr(ADDR_COMMAND, 32'h0009_0005);
        rd(ADDR_FLAGS, 32'h605);
        wr(ADDR_COMMAND, 32'h000A_0005);
        rd(ADDR_FLAGS, 32'h705);
        wr(ADDR_COMMAND, 32'h4);
        rd(ADDR_FLAGS, 32'h0);
        wr(ADDR_COMMAND, 32'h6);
        rd(ADDR_FLAGS, 32'h100);
        wr(ADDR_COMMAND, 32'h4);
        wr(ADDR_CONFIG, 32'h4);
        crit_in <= 8'h01;
        repeat (3) @(posedge clock);
        crit_in <= 8'h00;
        repeat (3) @(posedge clock);
        rd(ADDR_FLAGS, 32'h0);
        summarize();
    end
endmodule : mps_unit_tb
